// [common/abc_params.svh]
/*
  constants for the address-break comparator: bus widths, address compare masks
  and reset values. assumes inclusion by the package and the core files.
*/
`ifndef ABC_PARAMS_SVH
`define ABC_PARAMS_SVH

`define ABC_ADDR_W          16
`define ABC_DATA_W          16
`define ABC_ADDR_RESET      16'hFFFF
`define ABC_CTRL_RESET      8'h00
`define ABC_STAT_RSVD       6'h3F
`define ABC_AMASK_16        16'hFFFF
`define ABC_AMASK_12        16'hFFF0
`define ABC_AMASK_8         16'hFF00
`define ABC_AMASK_4         16'hF000

`endif

// [common/abc_pkg.sv]
/*
  types for the address-break comparator.
  assumes abc_params.svh is on the include path.
*/
`include "abc_params.svh"

package abc_pkg;

  // cycle type select, upper bits of the condition register
  typedef enum logic [1:0] {
    ABC_CYC_INSN  = 2'b00,
    ABC_CYC_READ  = 2'b01,
    ABC_CYC_WRITE = 2'b10,
    ABC_CYC_RW    = 2'b11
  } abc_cyc_e;

  // address compare width select
  typedef enum logic [2:0] {
    ABC_ACMP_16 = 3'b000,
    ABC_ACMP_12 = 3'b001,
    ABC_ACMP_8  = 3'b010,
    ABC_ACMP_4  = 3'b011
  } abc_acmp_e;

  // data compare select
  typedef enum logic [1:0] {
    ABC_DCMP_NONE = 2'b00,
    ABC_DCMP_LOW  = 2'b01,
    ABC_DCMP_HIGH = 2'b10,
    ABC_DCMP_WORD = 2'b11
  } abc_dcmp_e;

  // condition register contents
  typedef struct packed {
    logic      rtint;
    abc_cyc_e  cyc;
    logic [2:0] acmp;
    abc_dcmp_e dcmp;
  } abc_cond_s;

  // one observed cpu bus cycle
  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        read;
    logic        write;
    logic [15:0] addr;
    logic [15:0] data;
  } abc_bus_s;

  // software write port to the break registers
  typedef struct packed {
    logic        cond_we;
    abc_cond_s   cond;
    logic        stat_we;
    logic        flag_wdata;
    logic        ien_wdata;
    logic        stat_re;
    logic        addr_we;
    logic [15:0] addr;
    logic        data_we;
    logic [15:0] data;
  } abc_sw_s;

endpackage : abc_pkg

// [core/abc_match.sv]
/*
  combinational match of one bus cycle against the break settings.
  assumes the bus struct is valid in the cycle it is presented.
*/
`include "abc_params.svh"

module abc_match
  import abc_pkg::*;
(
  input  wire abc_bus_s    bus,
  input  wire abc_cond_s   cond,
  input  wire logic [15:0] brk_addr,
  input  wire logic [15:0] brk_data,
  output logic             hit
);

  logic [15:0] amask;    // address bits taking part
  logic        a_ok;     // address agrees
  logic        d_ok;     // data agrees
  logic        c_ok;     // cycle type agrees

  // compare logic
  always_comb begin
    unique case (cond.acmp)
      3'b000:  amask = `ABC_AMASK_16;
      3'b001:  amask = `ABC_AMASK_12;
      3'b010:  amask = `ABC_AMASK_8;
      3'b011:  amask = `ABC_AMASK_4;
      default: amask = 16'h0000;   // prohibited codes never match
    endcase
    a_ok = (cond.acmp[2] == 1'b0) && (((bus.addr ^ brk_addr) & amask) == 16'h0000);
    unique case (cond.dcmp)
      ABC_DCMP_NONE: d_ok = 1'b1;
      ABC_DCMP_LOW:  d_ok = (bus.data[7:0] == brk_data[7:0]);
      ABC_DCMP_HIGH: d_ok = (bus.data[15:8] == brk_data[15:8]);
      ABC_DCMP_WORD: d_ok = (bus.data == brk_data);
    endcase
    unique case (cond.cyc)
      ABC_CYC_INSN:  c_ok = bus.fetch;
      ABC_CYC_READ:  c_ok = bus.read;
      ABC_CYC_WRITE: c_ok = bus.write;
      ABC_CYC_RW:    c_ok = bus.read | bus.write;
    endcase
    hit = bus.valid & a_ok & d_ok & c_ok;
  end

endmodule : abc_match

// [core/abc_top.sv]
/*
  address-break comparator: break registers, match flag and nmi request.
  assumes the cpu presents each bus cycle for one clock with valid high,
  and that software accesses arrive as one-cycle strobes.
*/
// Notes on behaviour
// - request when flag and enable both set
// - flag sets only on full condition match
// - reset clears condition, flag, enable; address to all ones; hold when idle
// - break data survives reset, undefined at power-on
// - flag clears by write 0 after read 1
// - address compare width 16/12/8/4, 1xx prohibited
// - data compare none, low, high or word
// - break address resets to all ones
`include "abc_params.svh"

module abc_top
  import abc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        comp_active,   // active or subactive mode
  input  wire abc_bus_s    bus,
  input  wire abc_sw_s     sw,
  output abc_cond_s        cond,
  output logic             break_match_flag,
  output logic             break_irq_enable,
  output logic [7:0]       break_status_reg,
  output logic [15:0]      break_compare_address,
  output logic [15:0]      break_compare_data,
  output logic             nmi_req
);

  abc_cond_s   next_cond;        // condition register next
  logic        next_flag;        // match flag next
  logic        next_ien;         // enable next
  logic [15:0] next_addr;        // break address next
  logic [15:0] next_data;        // break data next
  logic        next_nmi;         // request next
  logic        flag_seen;        // flag read as 1 since last clear
  logic        next_seen;        // read-before-clear tracker next
  logic        hit;              // current cycle matches
  logic        hit_q;            // match registered one cycle
  logic        next_hit;         // registered match next

  // comparator
  abc_match u_match (
    .bus      (bus),
    .cond     (cond),
    .brk_addr (break_compare_address),
    .brk_data (break_compare_data),
    .hit      (hit)
  );

  // next-state for resettable registers
  always_comb begin
    next_cond = cond;
    next_flag = break_match_flag;
    next_ien  = break_irq_enable;
    next_addr = break_compare_address;
    next_seen = flag_seen;
    // a match only counts in active or subactive mode
    next_hit  = hit & comp_active;
    if (comp_active) begin
      if (sw.cond_we) begin
        next_cond = sw.cond;
      end
      if (sw.addr_we) begin
        next_addr = sw.addr;
      end
      if (sw.stat_re && break_match_flag) begin
        next_seen = 1'b1;
      end
      if (sw.stat_we) begin
        next_ien = sw.ien_wdata;
        if (!sw.flag_wdata && flag_seen) begin
          next_flag = 1'b0;
          next_seen = 1'b0;
        end
      end
      if (hit_q) begin
        next_flag = 1'b1;
      end
    end
    // flag set by a delayed hit wins over a clear in the same cycle
    next_nmi = next_flag & next_ien;
  end

  // resettable registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cond                  <= abc_cond_s'(`ABC_CTRL_RESET);
      break_match_flag      <= 1'b0;
      break_irq_enable      <= 1'b0;
      break_compare_address <= `ABC_ADDR_RESET;
      flag_seen             <= 1'b0;
      hit_q                 <= 1'b0;
      nmi_req               <= 1'b0;
      break_status_reg      <= {2'b00, `ABC_STAT_RSVD};
    end else begin
      cond                  <= next_cond;
      break_match_flag      <= next_flag;
      break_irq_enable      <= next_ien;
      break_compare_address <= next_addr;
      flag_seen             <= next_seen;
      hit_q                 <= next_hit;
      nmi_req               <= next_nmi;
      break_status_reg      <= {next_flag, next_ien, `ABC_STAT_RSVD};
    end
  end

  // break data next value
  always_comb begin
    next_data = break_compare_data;
    if (comp_active && sw.data_we) begin
      next_data = sw.data;
    end
  end

  // break data has no reset and keeps its value through one
  always_ff @(posedge sys_clk) begin
    break_compare_data <= next_data;
  end

  // checks
  a_irq_follows_flags: assert property (@(posedge sys_clk) disable iff (rst)
    nmi_req == (break_match_flag & break_irq_enable))
    else $error("request disagrees with flag and enable");

  sequence s_match;
    hit && comp_active;
  endsequence

  a_hit_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
    s_match |=> ##1 break_match_flag)
    else $error("match did not set flag");

  a_flag_needs_hit: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(break_match_flag) |-> $past(hit_q))
    else $error("flag set without match");

  a_clear_needs_read: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(break_match_flag) |-> $past(flag_seen) && $past(sw.stat_we) && !$past(sw.flag_wdata))
    else $error("flag cleared without read-then-write-0");

  a_idle_holds_regs: assert property (@(posedge sys_clk) disable iff (rst)
    !comp_active && !hit_q |=> $stable(cond) && $stable(break_compare_address)
      && $stable(break_match_flag) && $stable(break_compare_data))
    else $error("register changed while idle");

  a_bad_acmp_silent: assert property (@(posedge sys_clk) disable iff (rst)
    cond.acmp[2] |-> !hit)
    else $error("prohibited address code matched");

  a_word_data_exact: assert property (@(posedge sys_clk) disable iff (rst)
    hit && cond.dcmp == ABC_DCMP_WORD |-> bus.data == break_compare_data)
    else $error("word data compare wrong");

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    break_match_flag && !sw.stat_we |=> break_match_flag)
    else $error("flag dropped by itself");

  a_addr_exact16: assert property (@(posedge sys_clk) disable iff (rst)
    hit && cond.acmp == 3'b000 |-> bus.addr == break_compare_address)
    else $error("16-bit address compare wrong");

  // reset values held once reset has lasted a cycle
  a_reset_values: assert property (@(posedge sys_clk)
    rst && $past(rst) |-> break_compare_address == `ABC_ADDR_RESET && !break_match_flag
      && !break_irq_enable && !nmi_req && cond == abc_cond_s'(`ABC_CTRL_RESET))
    else $error("register not at reset value");

  // enable bit follows each accepted status write
  a_ien_write: assert property (@(posedge sys_clk) disable iff (rst)
    comp_active && sw.stat_we |=> break_irq_enable == $past(sw.ien_wdata))
    else $error("enable write lost");

  // break data write lands whole
  a_data_write: assert property (@(posedge sys_clk) disable iff (rst)
    comp_active && sw.data_we |=> break_compare_data == $past(sw.data))
    else $error("break data write lost");

  // break address write lands whole
  a_addr_write: assert property (@(posedge sys_clk) disable iff (rst)
    comp_active && sw.addr_we |=> break_compare_address == $past(sw.addr))
    else $error("break address write lost");

  // low byte compare uses the low data byte
  a_low_data_exact: assert property (@(posedge sys_clk) disable iff (rst)
    hit && cond.dcmp == ABC_DCMP_LOW |-> bus.data[7:0] == break_compare_data[7:0])
    else $error("low byte data compare wrong");

  // instruction breaks only on fetch cycles
  a_fetch_type: assert property (@(posedge sys_clk) disable iff (rst)
    hit && cond.cyc == ABC_CYC_INSN |-> bus.fetch)
    else $error("instruction break on a non-fetch cycle");

  // software read of the set flag
  sequence s_read_one;
    comp_active && sw.stat_re && break_match_flag;
  endsequence

  // write of 0 with no pending match to win over it
  sequence s_clear_req;
    comp_active && sw.stat_we && !sw.flag_wdata && !hit_q;
  endsequence

  // read of 1 then write of 0 clears the flag
  a_clear_after_read: assert property (@(posedge sys_clk) disable iff (rst)
    s_read_one ##1 s_clear_req |=> !break_match_flag)
    else $error("read-then-write-0 did not clear flag");

  // no clear while the flag has not been read as 1
  a_unread_keeps_flag: assert property (@(posedge sys_clk) disable iff (rst)
    break_match_flag && !flag_seen |=> break_match_flag)
    else $error("flag cleared without a prior read");

  // read tracker only arms on a read of the set flag
  a_seen_needs_read: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(flag_seen) |-> $past(sw.stat_re && break_match_flag && comp_active))
    else $error("read tracker armed without a read");

  // no match captured outside active modes
  a_inactive_no_capture: assert property (@(posedge sys_clk) disable iff (rst)
    !comp_active |=> !hit_q)
    else $error("match captured while idle");

endmodule : abc_top

// [verification/abc_cpu_model.sv]
/*
  cpu side model: drives one bus cycle at a time and takes the break nmi.
  assumes the bench calls cycle() just after a rising edge.
*/
module abc_cpu_model
  import abc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nmi_req,
  input  wire logic irq_mask,   // global mask, no effect on this request
  output abc_bus_s  bus,
  output logic      nmi_taken,   // exception entry seen
  output logic      taken_masked // entry made with the mask set
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    bus = '0;
    nmi_taken = 1'b0;
    taken_masked = 1'b0;
  end

  // one cycle held for one clock, then stale lines inverted
  task automatic cycle(input logic [2:0] kind, input logic [15:0] a, input logic [15:0] d);
    bus = {1'b1, kind, a, d};
    @(posedge sys_clk);
    #1;
    bus = {1'b0, 3'b000, ~a, ~d};
  endtask : cycle

  // entry only at the next fetch, mask ignored
  always @(posedge sys_clk) begin
    if (bus.valid && bus.fetch && nmi_req) begin
      nmi_taken    <= 1'b1;
      taken_masked <= irq_mask;
    end
  end
endmodule : abc_cpu_model

// [verification/abc_top_tb.sv]
/*
  bench for the address-break comparator: table of match cases, then
  clear, hold, nmi entry and reset cases. assumes a 100 MHz clock.
*/
module abc_top_tb
  import abc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    abc_cond_s   c;
    logic [2:0]  k;
    logic [15:0] a;
    logic [15:0] d;
    logic        hit;
  } abc_row_s;

  localparam logic [2:0] kf = 3'b100;  // fetch
  localparam logic [2:0] kr = 3'b010;  // read
  localparam logic [2:0] kw = 3'b001;  // write

  logic        sys_clk, rst, comp_active, irq_mask, nmi_taken, taken_masked, flag, ien, nmi;
  abc_bus_s    bus;
  abc_sw_s     sw;
  abc_cond_s   cond;
  logic [7:0]  stat;
  logic [15:0] baddr, bdata;
  int          errors, n_compared, i;

  // break address 1234, break data a55a
  abc_row_s rows [16] = '{
    '{8'h00, kf, 16'h1234, 16'h0000, 1'b1}, '{8'h00, kf, 16'h1235, 16'h0000, 1'b0},
    '{8'h24, kr, 16'h123F, 16'h0000, 1'b1}, '{8'h24, kr, 16'h1244, 16'h0000, 1'b0},
    '{8'h48, kw, 16'h12FF, 16'h0000, 1'b1}, '{8'h6C, kr, 16'h1FFF, 16'h0000, 1'b1},
    '{8'h6C, kw, 16'h2000, 16'h0000, 1'b0}, '{8'h21, kr, 16'h1234, 16'h005A, 1'b1},
    '{8'h21, kr, 16'h1234, 16'h0055, 1'b0}, '{8'h22, kr, 16'h1234, 16'hA500, 1'b1},
    '{8'h23, kr, 16'h1234, 16'hA55A, 1'b1}, '{8'h23, kr, 16'h1234, 16'hA55B, 1'b0},
    '{8'h10, kf, 16'h1234, 16'h0000, 1'b0}, '{8'h40, kr, 16'h1234, 16'h0000, 1'b0},
    '{8'h6C, kw, 16'h1000, 16'h0000, 1'b1}, '{8'h20, kf, 16'h1234, 16'h0000, 1'b0}};

  abc_top abc_top_inst (.sys_clk(sys_clk), .rst(rst), .comp_active(comp_active), .bus(bus), .sw(sw),
    .cond(cond), .break_match_flag(flag), .break_irq_enable(ien), .break_status_reg(stat),
    .break_compare_address(baddr), .break_compare_data(bdata), .nmi_req(nmi));
  abc_cpu_model abc_cpu_model_inst (.sys_clk(sys_clk), .nmi_req(nmi), .irq_mask(irq_mask),
    .bus(bus), .nmi_taken(nmi_taken), .taken_masked(taken_masked));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic stat_wr(input logic f, input logic e);
    sw.stat_we = 1'b1;
    sw.flag_wdata = f;
    sw.ien_wdata = e;
    tick;
    sw.stat_we = 1'b0;
  endtask : stat_wr

  // read as set, then write zero
  task automatic clr;
    sw.stat_re = 1'b1;
    tick;
    sw.stat_re = 1'b0;
    stat_wr(1'b0, 1'b1);
  endtask : clr

  task automatic setc(input abc_cond_s c);
    sw.cond = c;
    sw.cond_we = 1'b1;
    tick;
    sw.cond_we = 1'b0;
  endtask : setc

  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    test_done;
  end

  initial begin
    sw = '0;
    comp_active = 1'b1;
    irq_mask = 1'b0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    sw.addr = 16'h1234;
    sw.data = 16'hA55A;
    sw.addr_we = 1'b1;
    sw.data_we = 1'b1;
    stat_wr(1'b0, 1'b1);
    sw.addr_we = 1'b0;
    sw.data_we = 1'b0;
    for (i = 0; i < 16; i++) begin
      setc(rows[i].c);
      abc_cpu_model_inst.cycle(rows[i].k, rows[i].a, rows[i].d);
      chk(16'(flag), 16'h0000);
      tick;
      chk(16'(flag), 16'(rows[i].hit));
      chk(16'(nmi), 16'(rows[i].hit));
      clr;
      chk(16'(flag), 16'h0000);
      $display("row %0d done", i);
    end
    setc(8'h00);
    abc_cpu_model_inst.cycle(kf, 16'h1234, 16'h0000);
    tick;
    stat_wr(1'b0, 1'b0);
    chk(16'(flag), 16'h0001);
    chk(16'(nmi), 16'h0000);
    chk(16'(stat), 16'h00BF);
    clr;
    chk(16'(flag), 16'h0000);
    $display("clear test done");
    comp_active = 1'b0;
    abc_cpu_model_inst.cycle(kf, 16'h1234, 16'h0000);
    sw.addr = 16'h0000;
    sw.addr_we = 1'b1;
    tick;
    sw.addr_we = 1'b0;
    tick;
    chk(16'(flag), 16'h0000);
    chk(baddr, 16'h1234);
    comp_active = 1'b1;
    $display("hold test done");
    irq_mask = 1'b1;
    abc_cpu_model_inst.cycle(kf, 16'h1234, 16'h0000);
    tick;
    chk(16'(nmi), 16'h0001);
    chk(16'(nmi_taken), 16'h0000);
    abc_cpu_model_inst.cycle(kf, 16'h1236, 16'h0000);
    chk(16'(nmi_taken), 16'h0001);
    chk(16'(taken_masked), 16'h0001);
    $display("nmi test done");
    rst = 1'b1;
    tick;
    chk(16'(stat), 16'h003F);
    chk({8'h00, cond}, 16'h0000);
    chk(16'(nmi), 16'h0000);
    chk(16'(flag), 16'h0000);
    chk(baddr, 16'hFFFF);
    chk(bdata, 16'hA55A);
    rst = 1'b0;
    tick;
    chk(baddr, 16'hFFFF);
    chk(bdata, 16'hA55A);
    $display("reset test done");
    test_done;
  end
endmodule : abc_top_tb
